// *** logic/scd_consts.svh ***
// Bit positions, field widths and fixed codes of the serial command word.
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH
`define SCD_POS_IDX 5'd2
`define SCD_POS_LINE_LO 5'd4
`define SCD_POS_OP_LO 5'd9
`define SCD_POS_SEC_LO 5'd15
`define SCD_POS_LAST 5'd24
`define SCD_OP_W 6
`define SCD_LINE_W 5
`define SCD_SEC_W 8
`define SCD_FAST_W 4
`define SCD_FAST_LINE 5'h00
`define SCD_ALT_LINE_BIT 0
`define SCD_W20_BIT 4
`endif

// *** logic/scd_pkg.sv ***
// Types shared by the command class decoder files.
package scd_pkg;
  typedef enum logic [1:0] {
    SCD_CLS_NONE = 2'b00,
    SCD_CLS_ONE = 2'b01,
    SCD_CLS_TWO = 2'b10,
    SCD_CLS_THREE = 2'b11
  } scd_class_t;
endpackage : scd_pkg

// *** logic/scd_class_rom.sv ***
// Op code to timing class, dual meaning and branch lookup.
`timescale 1ns/1ns
module scd_class_rom
  import scd_pkg::*;
(
  input wire logic [5:0] op_in,
  output scd_class_t cls_out,
  output logic dual_out,
  output logic branch_out
);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (op_in) inside
      [6'h10:6'h16], [6'h18:6'h1b], [6'h30:6'h37], [6'h38:6'h3b]:
        cls_out = SCD_CLS_ONE;
      6'h00, 6'h01, 6'h02, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0d,
      [6'h20:6'h27], [6'h28:6'h2b], [6'h2d:6'h2f]:
        cls_out = SCD_CLS_TWO;
      6'h03, 6'h07, 6'h0b, 6'h0e, 6'h0f, [6'h1c:6'h1f], 6'h3d, 6'h3f:
        cls_out = SCD_CLS_THREE;
      default:
        cls_out = SCD_CLS_NONE;
    endcase
  end

  // Codes whose meaning is picked by the address field.
  assign dual_out = (op_in == 6'h00) || (op_in == 6'h10) || (op_in == 6'h11) ||
                    (op_in == 6'h12) || (op_in == 6'h19) || (op_in == 6'h1b);

  // Conditional transfers that the branch condition flag steers.
  assign branch_out = ((op_in >= 6'h1c) && (op_in <= 6'h1f)) ||
                      (op_in == 6'h3d) || (op_in == 6'h3f);

endmodule : scd_class_rom

// *** logic/scd_decoder.sv ***
// Serial command word capture and execution class decoder.
//
// Contract
// - Bits 9 to 14 of each serial command word are caught in six op code flops.
// - Codes 20-26, 30-33, 60-67, 70-73 octal are class one, run up to the address sector.
// - Codes 00-02, 04-06, 10-12, 14, 15, 40-47, 50-53, 55-57 octal are class two.
// - Codes 03, 07, 13, 16, 17, 34-37, 75, 77 octal are class three, two sectors.
// - Codes 00, 20, 21, 22, 31, 33 pick one of two operations from the address field.
// - A long line holds 256 sectors, so the sector part of an address is eight bits.
// - Line 00 is a fast line of 16 words, each recurring 16 times per long circulation.
// - Every command carries one operand address, optionally modified by the index.
// - Codes with the weight-20 bit set go straight to execution, ending at the address sector.
// - For branch codes the condition flag chooses between transfer and next command.
// - Command bit 2 is held and selects the operand line from the index or the command.
`timescale 1ns/1ns
`include "scd_consts.svh"
module scd_decoder
  import scd_pkg::*;
#(
  parameter int OP_W = `SCD_OP_W,
  parameter int LINE_W = `SCD_LINE_W,
  parameter int SEC_W = `SCD_SEC_W,
  parameter int FAST_W = `SCD_FAST_W
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CMD_BIT_IN,
  input wire logic CMD_BIT_VALID_IN,
  input wire logic [4:0] BIT_POS_IN,
  input wire logic [LINE_W-1:0] INDEX_LINE_IN,
  input wire logic BRANCH_COND_IN,
  output logic DECODE_VALID_OUT,
  output logic [OP_W-1:0] OPCODE_OUT,
  output scd_class_t CLASS_OUT,
  output logic UNDEFINED_OUT,
  output logic DUAL_MEANING_OUT,
  output logic ALT_OP_OUT,
  output logic DIRECT_EXEC_OUT,
  output logic BRANCH_TAKE_OUT,
  output logic BRANCH_SKIP_OUT,
  output logic INDEX_SELECT_OUT,
  output logic [LINE_W-1:0] OPERAND_LINE_OUT,
  output logic [SEC_W-1:0] OPERAND_SECTOR_OUT,
  output logic FAST_LINE_OUT,
  output logic [FAST_W-1:0] FAST_WORD_OUT
);

  logic [OP_W-1:0] op_q;
  logic [LINE_W-1:0] line_q;
  logic [SEC_W-1:0] sec_q;
  logic [OP_W-1:0] op_d;
  logic [LINE_W-1:0] line_d;
  logic [SEC_W-1:0] sec_d;
  logic idx_sel_q;
  scd_class_t cls;
  logic dual;
  logic branch;
  logic word_end;
  logic [LINE_W-1:0] eff_line;

  ////////////////////////////////////////////////////////////////////////////
  // Field capture. Each flop loads only at its own bit time, so a stray
  // bit outside the read phase cannot disturb a held command.
  assign word_end = CMD_BIT_VALID_IN && (BIT_POS_IN == `SCD_POS_LAST);

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      idx_sel_q <= 1'b0;
    else if (CMD_BIT_VALID_IN && (BIT_POS_IN == `SCD_POS_IDX))
      idx_sel_q <= CMD_BIT_IN;
  end

  genvar gi;
  generate
    for (gi = 0; gi < OP_W; gi++)
    begin : g_op
      assign op_d[gi] = (CMD_BIT_VALID_IN && (BIT_POS_IN == 5'(`SCD_POS_OP_LO + gi))) ?
                        CMD_BIT_IN : op_q[gi];
    end
    for (gi = 0; gi < LINE_W; gi++)
    begin : g_line
      assign line_d[gi] = (CMD_BIT_VALID_IN && (BIT_POS_IN == 5'(`SCD_POS_LINE_LO + gi))) ?
                          CMD_BIT_IN : line_q[gi];
    end
    for (gi = 0; gi < SEC_W; gi++)
    begin : g_sec
      assign sec_d[gi] = (CMD_BIT_VALID_IN && (BIT_POS_IN == 5'(`SCD_POS_SEC_LO + gi))) ?
                         CMD_BIT_IN : sec_q[gi];
    end
  endgenerate

  // One process owns each field register, so no bit has two writers.
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      op_q <= '0;
      line_q <= '0;
      sec_q <= '0;
    end
    else
    begin
      op_q <= op_d;
      line_q <= line_d;
      sec_q <= sec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode.
  scd_class_rom u_rom (
    .op_in(op_q),
    .cls_out(cls),
    .dual_out(dual),
    .branch_out(branch)
  );

  // One operand address: the line comes from the index or the command.
  assign eff_line = idx_sel_q ? INDEX_LINE_IN : line_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output flops, loaded once per command at the last bit time so that the
  // datapath never sees a half-shifted op code.
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      DECODE_VALID_OUT <= 1'b0;
    else
      DECODE_VALID_OUT <= word_end;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      OPCODE_OUT <= '0;
      CLASS_OUT <= SCD_CLS_NONE;
      UNDEFINED_OUT <= 1'b0;
      DUAL_MEANING_OUT <= 1'b0;
      ALT_OP_OUT <= 1'b0;
      DIRECT_EXEC_OUT <= 1'b0;
      BRANCH_TAKE_OUT <= 1'b0;
      BRANCH_SKIP_OUT <= 1'b0;
      INDEX_SELECT_OUT <= 1'b0;
      OPERAND_LINE_OUT <= '0;
      OPERAND_SECTOR_OUT <= '0;
      FAST_LINE_OUT <= 1'b0;
      FAST_WORD_OUT <= '0;
    end
    else if (word_end)
    begin
      OPCODE_OUT <= op_q;
      CLASS_OUT <= cls;
      UNDEFINED_OUT <= (cls == SCD_CLS_NONE);
      DUAL_MEANING_OUT <= dual;
      ALT_OP_OUT <= dual && line_q[`SCD_ALT_LINE_BIT];
      DIRECT_EXEC_OUT <= op_q[`SCD_W20_BIT];
      BRANCH_TAKE_OUT <= branch && BRANCH_COND_IN;
      BRANCH_SKIP_OUT <= branch && !BRANCH_COND_IN;
      INDEX_SELECT_OUT <= idx_sel_q;
      OPERAND_LINE_OUT <= eff_line;
      OPERAND_SECTOR_OUT <= sec_q;
      FAST_LINE_OUT <= (eff_line == `SCD_FAST_LINE);
      FAST_WORD_OUT <= sec_q[FAST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_op_capture;
    CMD_BIT_VALID_IN && (BIT_POS_IN == `SCD_POS_OP_LO) |=> op_q[0] == $past(CMD_BIT_IN);
  endproperty
  a_op_capture: assert property (p_op_capture) else $error("op bit 0 lost");

  property p_op_out;
    word_end |=> OPCODE_OUT == $past(op_q) && DECODE_VALID_OUT;
  endproperty
  a_op_out: assert property (p_op_out) else $error("op code not presented");

  property p_class_one;
    DECODE_VALID_OUT && (OPCODE_OUT inside {[6'h10:6'h16], [6'h18:6'h1b], [6'h30:6'h3b]})
      |-> CLASS_OUT == SCD_CLS_ONE;
  endproperty
  a_class_one: assert property (p_class_one) else $error("class one wrong");

  property p_class_two;
    DECODE_VALID_OUT && (OPCODE_OUT inside {[6'h20:6'h2b], [6'h2d:6'h2f]})
      |-> CLASS_OUT == SCD_CLS_TWO;
  endproperty
  a_class_two: assert property (p_class_two) else $error("class two wrong");

  property p_class_three;
    DECODE_VALID_OUT && (OPCODE_OUT inside {[6'h1c:6'h1f], 6'h3d, 6'h3f, 6'h03})
      |-> CLASS_OUT == SCD_CLS_THREE;
  endproperty
  a_class_three: assert property (p_class_three) else $error("class three wrong");

  property p_alt;
    word_end |=> ALT_OP_OUT == ((OPCODE_OUT inside {6'h00, 6'h10, 6'h11, 6'h12, 6'h19, 6'h1b})
      && $past(line_q[`SCD_ALT_LINE_BIT]));
  endproperty
  a_alt: assert property (p_alt) else $error("alt op wrong");

  property p_sector;
    word_end |=> OPERAND_SECTOR_OUT == $past(sec_q) && FAST_WORD_OUT == $past(sec_q[FAST_W-1:0]);
  endproperty
  a_sector: assert property (p_sector) else $error("sector field wrong");

  property p_fast;
    DECODE_VALID_OUT |-> FAST_LINE_OUT == (OPERAND_LINE_OUT == `SCD_FAST_LINE);
  endproperty
  a_fast: assert property (p_fast) else $error("fast line flag wrong");

  property p_index;
    word_end |=> OPERAND_LINE_OUT == ($past(idx_sel_q) ? $past(INDEX_LINE_IN) : $past(line_q));
  endproperty
  a_index: assert property (p_index) else $error("operand line source wrong");

  property p_direct;
    DECODE_VALID_OUT |-> DIRECT_EXEC_OUT == (OPCODE_OUT inside {[6'h10:6'h1f], [6'h30:6'h3f]});
  endproperty
  a_direct: assert property (p_direct) else $error("direct exec wrong");

  property p_branch;
    word_end |=> BRANCH_TAKE_OUT == ((OPCODE_OUT inside {[6'h1c:6'h1f], 6'h3d, 6'h3f})
      && $past(BRANCH_COND_IN));
  endproperty
  a_branch: assert property (p_branch) else $error("branch take wrong");

  property p_undef;
    DECODE_VALID_OUT && (OPCODE_OUT inside {6'h17, 6'h2c, 6'h3c, 6'h3e})
      |-> UNDEFINED_OUT && CLASS_OUT == SCD_CLS_NONE;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code classed");

  c_branch_taken: cover property (DECODE_VALID_OUT && BRANCH_TAKE_OUT);
  c_branch_skip: cover property (DECODE_VALID_OUT && BRANCH_SKIP_OUT);
  c_alt_op: cover property (DECODE_VALID_OUT && ALT_OP_OUT);
  c_undef: cover property (DECODE_VALID_OUT && UNDEFINED_OUT);

endmodule : scd_decoder

// *** testbench/scd_cmd_source.sv ***
// Behavioural source of serial command words for the class decoder.
`timescale 1ns/1ns
module scd_cmd_source
(
  input wire logic clk_in,
  output logic bit_out,
  output logic valid_out,
  output logic [4:0] pos_out
);
  initial
  begin
    bit_out = 1'b0;
    valid_out = 1'b0;
    pos_out = 5'h00;
  end
  // One bit a cycle, bit times 1 to 24, with the op code in bit times 9 to 14.
  task automatic send(input logic [24:0] w, input logic last);
    int p;
    for (p = 1; p <= 24; p++)
    begin
      @(negedge clk_in);
      bit_out = w[p];
      valid_out = 1'b1;
      pos_out = 5'(p);
    end
    if (last)
    begin
      @(negedge clk_in);
      valid_out = 1'b0;
      pos_out = 5'h00;
      bit_out = ~bit_out;
    end
  endtask : send
  // A released line toggles, so a stale bit can never pass for a real one.
  task automatic noise(input int n);
    repeat (n)
    begin
      @(negedge clk_in);
      valid_out = 1'b0;
      pos_out = 5'h18;
      bit_out = ~bit_out;
    end
  endtask : noise
endmodule : scd_cmd_source

// *** testbench/tb.sv ***
// Self-checking bench for the command class decoder.
`timescale 1ns/1ns
module tb;
  import scd_pkg::*;
  logic clk, rst, cond, bit_w, val_w;
  logic [4:0] idx_line, pos_w, ln;
  logic dv, und, dual, alt, dir, tk, sk, isel, fl;
  logic [5:0] op;
  scd_class_t cls;
  logic [7:0] sec;
  logic [3:0] fw;
  logic [24:0] w1, w2;
  int mismatches = 0;
  int n_compared = 0;
  scd_decoder scd_decoder_i (.CLK_IN(clk), .RST_IN(rst), .CMD_BIT_IN(bit_w),
    .CMD_BIT_VALID_IN(val_w), .BIT_POS_IN(pos_w), .INDEX_LINE_IN(idx_line),
    .BRANCH_COND_IN(cond), .DECODE_VALID_OUT(dv), .OPCODE_OUT(op), .CLASS_OUT(cls),
    .UNDEFINED_OUT(und), .DUAL_MEANING_OUT(dual), .ALT_OP_OUT(alt), .DIRECT_EXEC_OUT(dir),
    .BRANCH_TAKE_OUT(tk), .BRANCH_SKIP_OUT(sk), .INDEX_SELECT_OUT(isel),
    .OPERAND_LINE_OUT(ln), .OPERAND_SECTOR_OUT(sec), .FAST_LINE_OUT(fl), .FAST_WORD_OUT(fw));
  scd_cmd_source scd_cmd_source_i (.clk_in(clk), .bit_out(bit_w), .valid_out(val_w),
    .pos_out(pos_w));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1
  function automatic scd_class_t exp_cls(input logic [5:0] o);
    if (o inside {[6'h10:6'h16], [6'h18:6'h1b], [6'h30:6'h3b]})
      return SCD_CLS_ONE;
    if (o inside {[6'h00:6'h02], [6'h04:6'h06], [6'h08:6'h0a], 6'h0c, 6'h0d, [6'h20:6'h2b],
      [6'h2d:6'h2f]})
      return SCD_CLS_TWO;
    if (o inside {6'h03, 6'h07, 6'h0b, 6'h0e, 6'h0f, [6'h1c:6'h1f], 6'h3d, 6'h3f})
      return SCD_CLS_THREE;
    return SCD_CLS_NONE;
  endfunction : exp_cls
  // Ignored bit times 1, 3 and 23 are set so that a stray capture shows up.
  function automatic logic [24:0] mkw(input logic [5:0] o, input logic [4:0] l,
    input logic [7:0] s, input logic ix);
    return {1'b0, 1'b1, s, o, l, 1'b1, ix, 1'b1, 1'b0};
  endfunction : mkw
  // Called in the cycle after bit 24, where the pulse and the new outputs stand.
  task automatic check(input logic [24:0] w);
    logic [5:0] o;
    logic br, du;
    logic [4:0] l;
    o = w[14:9];
    br = o inside {[6'h1c:6'h1f], 6'h3d, 6'h3f};
    du = o inside {6'h00, 6'h10, 6'h11, 6'h12, 6'h19, 6'h1b};
    l = w[2] ? idx_line : w[8:4];
    cmp1(dv, 1'b1);
    cmp8({2'h0, op}, {2'h0, o});
    cmp8({6'h00, cls}, {6'h00, exp_cls(o)});
    cmp1(und, exp_cls(o) == SCD_CLS_NONE);
    cmp1(dual, du);
    cmp1(alt, du & w[4]);
    cmp1(dir, o[4]);
    cmp1(tk, br & cond);
    cmp1(sk, br & ~cond);
    cmp1(isel, w[2]);
    cmp8({3'h0, ln}, {3'h0, l});
    cmp8(sec, w[22:15]);
    cmp1(fl, l == 5'h00);
    cmp8({4'h0, fw}, {4'h0, w[18:15]});
  endtask : check
  task automatic one(input logic [24:0] w);
    scd_cmd_source_i.send(w, 1'b1);
    check(w);
  endtask : one
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_sweep();
    for (int i = 0; i < 64; i++)
    begin
      cond = i[1];
      idx_line = 5'(i);
      one(mkw(6'(i), 5'(i) ^ 5'h15, 8'(i * 4 + 1), i[0]));
    end
  endtask : t_sweep
  // Two words with no gap, at the sector extremes, the second fast through the index.
  task automatic t_fields();
    idx_line = 5'h00;
    cond = 1'b1;
    w1 = mkw(6'h05, 5'h1f, 8'hff, 1'b0);
    w2 = mkw(6'h3f, 5'h0a, 8'h00, 1'b1);
    scd_cmd_source_i.send(w1, 1'b0);
    @(posedge clk);
    #1;
    check(w1);
    one(w2);
    one(mkw(6'h19, 5'h00, 8'h0f, 1'b0));
  endtask : t_fields
  task automatic t_refuse();
    scd_cmd_source_i.noise(5);
    cmp1(dv, 1'b0);
    cmp8({6'h00, cls}, {6'h00, SCD_CLS_ONE});
    cmp8({2'h0, op}, 8'h19);
  endtask : t_refuse
  task automatic t_reset();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    cmp8({6'h00, cls}, 8'h00);
    cmp8({2'h0, op}, 8'h00);
    one(mkw(6'h17, 5'h03, 8'h42, 1'b0));
  endtask : t_reset
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    idx_line = 5'h00;
    cond = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_sweep();
    t_fields();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule : tb
